// >>> rtl/pcnt_pkg.sv
/*
  constants and types for the presettable 4-bit synchronous counter.
  assumes a 32-bit apb register bus with 12-bit byte addresses.
*/
package pcnt_pkg;

  // ------------------------------------------------------------
  // counter geometry
  // ------------------------------------------------------------
  localparam int          CNT_W    = 4;
  localparam logic [3:0]  CNT_ZERO = 4'h0;
  localparam logic [3:0]  CNT_ONE  = 4'h1;
  localparam logic [3:0]  CNT_MAX  = 4'hF;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam int          CTRL_LOAD_BIT = 0;
  localparam int          CTRL_VAL_LSB  = 4;
  localparam int          STAT_CRY_BIT  = 4;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
  localparam logic [3:0]  VAL_RESET     = 4'h0;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PCNT_HOLD,
    PCNT_COUNT,
    PCNT_LOAD
  } pcnt_mode_type;

  typedef struct packed {
    logic       load_req;
    logic [3:0] value;
  } pcnt_soft_load_type;

  typedef struct packed {
    logic       carry;
    logic [3:0] count;
  } pcnt_status_type;

endpackage

// >>> rtl/pcnt_counter.sv
/*
  presettable 4-bit synchronous binary up counter with apb status/control.
  assumes all pin inputs synchronous to sys_clk; async_clear_n may fall
  at any time and should be released clear of a rising edge.
*/
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module pcnt_counter (
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic                        async_clear_n,
  input  wire logic                        sync_load_n,
  input  wire logic                        parallel_count_enable,
  input  wire logic                        trickle_count_enable,
  input  wire logic [pcnt_pkg::CNT_W-1:0]  preset_data,
  output logic                             count_bit0,
  output logic                             count_bit1,
  output logic                             count_bit2,
  output logic                             count_bit3,
  output logic                             ripple_carry_out,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pcnt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr
);
  import pcnt_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // mode select
  // ------------------------------------------------------------
  logic               [3:0] count_q;
  logic               [3:0] count_d;
  pcnt_soft_load_type       soft_q;
  pcnt_mode_type            mode;
  wire logic                zero_n    = rst_n_q & async_clear_n;
  wire logic                pin_load  = ~sync_load_n;
  wire logic                cnt_en    = parallel_count_enable & trickle_count_enable;
  wire logic                any_load  = pin_load | soft_q.load_req;
  wire logic          [3:0] load_val  = pin_load ? preset_data : soft_q.value;
  wire logic                at_max    = (count_q == CNT_MAX);

  assign mode = any_load ? PCNT_LOAD : (cnt_en ? PCNT_COUNT : PCNT_HOLD);

  always_comb begin
    unique case (mode)
      PCNT_LOAD:  count_d = load_val;
      PCNT_COUNT: count_d = CNT_W'(count_q + CNT_ONE);
      PCNT_HOLD:  count_d = count_q;
    endcase
  end

  // ------------------------------------------------------------
  // count flops
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge zero_n) begin
    if (!zero_n) begin
      count_q <= CNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_bit0       = count_q[0];
  assign count_bit1       = count_q[1];
  assign count_bit2       = count_q[2];
  assign count_bit3       = count_q[3];
  assign ripple_carry_out = at_max & trickle_count_enable;

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  pcnt_status_type  status;
  logic      [31:0] rdata_q;
  logic      [31:0] rdata_d;
  wire logic        hit_ctrl  = (paddr == ADDR_CTRL);
  wire logic        hit_stat  = (paddr == ADDR_STATUS);
  wire logic        setup     = psel & ~penable;
  wire logic        access    = psel & penable;
  wire logic        bad_acc   = ~hit_ctrl & ~(hit_stat & ~pwrite);
  wire logic        ctrl_wr   = access & pwrite & hit_ctrl;

  assign status.carry = ripple_carry_out;
  assign status.count = count_q;

  always_comb begin
    rdata_d = RDATA_ZERO;
    if (hit_stat) begin
      rdata_d[STAT_CRY_BIT:0] = status;
    end else if (hit_ctrl) begin
      rdata_d[CTRL_VAL_LSB +: CNT_W] = soft_q.value;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= RDATA_ZERO;
    end else if (setup) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      soft_q.load_req <= 1'b0;
      soft_q.value    <= VAL_RESET;
    end else if (ctrl_wr) begin
      soft_q.load_req <= pwdata[CTRL_LOAD_BIT];
      soft_q.value    <= pwdata[CTRL_VAL_LSB +: CNT_W];
    end else begin
      soft_q.load_req <= 1'b0;
    end
  end

  assign pready  = penable;
  assign prdata  = rdata_q;
  assign pslverr = access & bad_acc;

  // ------------------------------------------------------------
  // checks: load and count
  // ------------------------------------------------------------

  load_copies_a: assert property (
    @(posedge sys_clk) disable iff (!zero_n)
    !sync_load_n
      |=> count_q == $past(preset_data))
    else $error("pin load did not copy preset data");

  load_en_off_a: assert property (
    @(posedge sys_clk) disable iff (!zero_n)
    (!sync_load_n && !parallel_count_enable && !trickle_count_enable)
      |=> count_q == $past(preset_data))
    else $error("pin load blocked by low enables");

  count_step_a: assert property (
    @(posedge sys_clk) disable iff (!zero_n)
    (sync_load_n && !soft_q.load_req && parallel_count_enable && trickle_count_enable)
      |=> count_q == CNT_W'($past(count_q) + CNT_ONE))
    else $error("count did not step by one");

  hold_count_a: assert property (
    @(posedge sys_clk) disable iff (!zero_n)
    (sync_load_n && !soft_q.load_req && !(parallel_count_enable && trickle_count_enable))
      |=> $stable(count_q))
    else $error("count moved while inhibited");

  trickle_off_hold_a: assert property (
    @(posedge sys_clk) disable iff (!zero_n)
    (sync_load_n && !soft_q.load_req && !trickle_count_enable)
      |=> $stable(count_q))
    else $error("count moved with trickle enable low");

  wrap_zero_a: assert property (
    @(posedge sys_clk) disable iff (!zero_n)
    (count_q == CNT_MAX && sync_load_n && !soft_q.load_req && cnt_en)
      |=> count_q == CNT_ZERO ##1 (!$past(cnt_en) || !$past(sync_load_n) || $past(soft_q.load_req) || count_q == CNT_ONE))
    else $error("count did not wrap to zero and continue");

  soft_load_a: assert property (
    @(posedge sys_clk) disable iff (!zero_n)
    (ctrl_wr && pwdata[CTRL_LOAD_BIT]) ##1 sync_load_n
      |=> count_q == $past(soft_q.value))
    else $error("soft load did not take effect");

  soft_pulse_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (soft_q.load_req && !ctrl_wr)
      |=> !soft_q.load_req)
    else $error("soft load request stayed high");

  // ------------------------------------------------------------
  // checks: carry
  // ------------------------------------------------------------

  carry_level_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    1'b1
      |-> ripple_carry_out == (count_q == CNT_MAX && trickle_count_enable))
    else $error("ripple carry level wrong");

  carry_gate_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (count_q == CNT_MAX && trickle_count_enable && !parallel_count_enable)
      |-> ripple_carry_out)
    else $error("parallel enable affected ripple carry");

  carry_low_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (count_q != CNT_MAX || !trickle_count_enable)
      |-> !ripple_carry_out)
    else $error("ripple carry high off terminal count");

  // ------------------------------------------------------------
  // checks: clear and reset
  // ------------------------------------------------------------

  clear_wins_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    !async_clear_n
      |-> count_q == CNT_ZERO)
    else $error("clear did not force zero");

  reset_zero_a: assert property (
    @(posedge sys_clk)
    !rst_n_q
      |-> (count_q == CNT_ZERO && prdata == RDATA_ZERO && !soft_q.load_req))
    else $error("reset left state nonzero");

  // ------------------------------------------------------------
  // checks: apb
  // ------------------------------------------------------------

  status_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (setup && !pwrite && hit_stat)
      |=> prdata[CNT_W-1:0] == $past(count_q))
    else $error("status read returned stale count");

  status_carry_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (setup && !pwrite && hit_stat)
      |=> prdata[STAT_CRY_BIT] == $past(ripple_carry_out))
    else $error("status read returned wrong carry");

  ctrl_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (setup && !pwrite && hit_ctrl)
      |=> prdata[CTRL_VAL_LSB +: CNT_W] == $past(soft_q.value))
    else $error("control read returned wrong value");

  prdata_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    !setup
      |=> $stable(prdata))
    else $error("read data moved outside setup");

  ctrl_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    ctrl_wr
      |=> soft_q.value == $past(pwdata[CTRL_VAL_LSB +: CNT_W]))
    else $error("control write did not land");

  bad_write_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (access && pwrite && !hit_ctrl)
      |=> ($stable(soft_q.value) && !soft_q.load_req))
    else $error("refused write changed control state");

  bad_err_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (access && pwrite && hit_stat)
      |-> pslverr)
    else $error("status write not flagged");

  ctrl_ok_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n_q)
    (access && hit_ctrl)
      |-> !pslverr)
    else $error("control access flagged as error");

  // ------------------------------------------------------------
  // covers
  // ------------------------------------------------------------

  cover_wrap_c:  cover property (@(posedge sys_clk) disable iff (!zero_n)
    count_q == CNT_MAX ##1 count_q == CNT_ZERO);
  cover_load_c:  cover property (@(posedge sys_clk) disable iff (!zero_n)
    !sync_load_n && cnt_en);
  cover_clear_c: cover property (@(posedge sys_clk) disable iff (!rst_n_q)
    count_q != CNT_ZERO ##1 !async_clear_n);
  cover_carry_c: cover property (@(posedge sys_clk) disable iff (!rst_n_q)
    ripple_carry_out && !parallel_count_enable);
  cover_soft_c:  cover property (@(posedge sys_clk) disable iff (!zero_n)
    soft_q.load_req && sync_load_n);

endmodule
`default_nettype wire

// >>> verification/pcnt_cascade_model.sv
/*
  upper counter stage model fed by the lower stage carry.
  assumes the same sys_clk and reset_n as the counter.
*/
`timescale 1ns/10ps
`default_nettype none
module pcnt_cascade_model (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       carry_in,
  input  wire logic       par_en,
  output logic      [3:0] upper_q
);
  // carry plus shared enable steps the next stage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      upper_q <= 4'h0;
    end else if (carry_in && par_en) begin
      upper_q <= upper_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> verification/pcnt_counter_tb_top.sv
/*
  self-checking bench for the counter pins and apb registers.
  assumes pcnt_pkg and the cascade model.
*/
`timescale 1ns/10ps
`default_nettype none
module pcnt_counter_tb_top;
  import pcnt_pkg::*;
  logic        sys_clk, reset_n, clear_n, ld_n, pen, ten, psel, penable, pwrite;
  logic        b0, b1, b2, b3, carry, pready, pslverr, e;
  logic [3:0]  pd, up, u0, v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int          failures, check_count, i;
  wire logic [3:0] cnt = {b3, b2, b1, b0};
  pcnt_counter DUT (.sys_clk(sys_clk), .reset_n(reset_n), .async_clear_n(clear_n), .sync_load_n(ld_n),
    .parallel_count_enable(pen), .trickle_count_enable(ten), .preset_data(pd), .count_bit0(b0),
    .count_bit1(b1), .count_bit2(b2), .count_bit3(b3), .ripple_carry_out(carry), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));
  pcnt_cascade_model upper (.sys_clk(sys_clk), .reset_n(reset_n), .carry_in(carry), .par_en(pen), .upper_q(up));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  task stop_test;
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // drive at an edge, look at the following negedge
  task step(input logic l, p, t, input logic [3:0] d);
    @(posedge sys_clk);
    ld_n <= l;
    pen <= p;
    ten <= t;
    pd <= d;
    @(negedge sys_clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_load;
    for (i = 0; i < 17; i++) begin
      step(i > 15, i[0], i[1], i[3:0]);
      if (i > 0) chk("load", i - 1, cnt);
    end
  endtask
  task t_count;
    step(1'b0, 1'b0, 1'b0, 4'hC);
    v = 4'hC;
    for (i = 0; i < 7; i++) begin
      step(1'b1, 1'b1, 1'b1, 4'h0);
      if (i == 0) u0 = up;
      chk("count", v, cnt);
      chk("carry", v == 4'hF, carry);
      #4 chk("fall edge", v, cnt);
      v = v + 4'h1;
    end
    chk("upper", u0 + 4'h1, up);
    step(1'b1, 1'b0, 1'b1, 4'h0);
    step(1'b1, 1'b1, 1'b0, 4'h0);
    chk("hold", 4'h3, cnt);
    step(1'b1, 1'b1, 1'b1, 4'h0);
    chk("hold", 4'h3, cnt);
  endtask
  task t_clear;
    @(posedge sys_clk);
    clear_n <= 1'b0;
    ld_n <= 1'b0;
    #2 chk("clear", 4'h0, cnt);
    @(negedge sys_clk);
    chk("clear", 4'h0, cnt);
    @(posedge sys_clk);
    clear_n <= 1'b1;
  endtask
  task t_regs;
    step(1'b0, 1'b0, 1'b1, 4'hF);
    step(1'b1, 1'b0, 1'b1, 4'h0);
    chk("carry", 1'b1, carry);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_001F, r);
    step(1'b1, 1'b1, 1'b0, 4'h0);
    chk("carry", 1'b0, carry);
    step(1'b1, 1'b0, 1'b0, 4'h0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0091);
    chk("wr err", 1'b0, e);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("soft load", 32'h0000_0009, r);
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_0090, r);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("unmapped", 1'b1, e);
    apb(1'b1, ADDR_STATUS, 32'h0000_0005);
    chk("ro", 1'b1, e);
  endtask
  initial begin
    #100000;
    failures++;
    stop_test;
  end
  initial begin
    {reset_n, ld_n, pen, ten, pd, psel, penable, pwrite, paddr, pwdata} = '0;
    clear_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_load;
    t_count;
    t_clear;
    t_regs;
    stop_test;
  end
endmodule
`default_nettype wire
